// >>> atcal_core.sv
// ambient tracking and adaptive touch limit engine, one stage per pass
//
// What this block does
// R1 - compensate after each conversion, untouched, once enabled
// R2 - keep per-stage slow baseline from slow filter
// R3 - lower limit: base, quarter span, scaled remainder
// R4 - upper limit: base, quarter span, scaled fraction
// R5 - host sets sensitivity codes once at startup
// R6 - recompute both limits whenever spans change
// R7 - readjust spans from measured ambient drift
// R8 - host writes initial spans, about 80% clamp
// R9 - clamps keep tracked response in nominal range
// R10 - host programs upper and lower clamp values
// R11 - max average updates only inside rise window
// R12 - min average updates only inside fall window
// R13 - assert active-low alert on limit crossing
// R14 - keep per-stage state and setup in RAM
// R15 - three control registers at 0x002 to 0x004
// R16 - rise checks upper limit, fall lower limit
// R17 - sensitivity code gives sixteen levels, 25%-95%
// R18 - slow filter moves only when enabled, no proximity
// R19 - upper scaled term mirrors lower term form
// R20 - span updates saturate at the clamp values
`timescale 1ns/1ps
module atcal_core
	import atcal_pkg::*;
#(
	parameter int STAGES = 12,
	parameter int STAGE_W = 4
) (
	input wire logic ref_clk, // 125 MHz clock
	input wire logic srst, // synchronous reset, high
	input wire logic [ATCAL_ADDR_W-1:0] reg_addr, // register address
	input wire logic reg_wr, // register write strobe
	input wire logic [15:0] reg_wdata, // register write data
	output logic [15:0] reg_rdata, // register read data
	input wire logic setup_wr, // per-stage setup write
	output logic setup_ready, // setup write taken
	input wire logic [STAGE_W-1:0] setup_stage, // stage being set up
	input wire atcal_setup_s setup_data, // stage setup record
	input wire logic conv_valid, // conversion result offered
	output logic conv_ready, // conversion taken
	input wire logic [STAGE_W-1:0] conv_stage, // stage of result
	input wire logic [15:0] conv_data, // converter output
	input wire logic prox_active, // proximity condition active
	output logic res_valid, // result pulse
	output logic [STAGE_W-1:0] res_stage, // stage of result
	output logic touch_hi, // upper limit crossed
	output logic touch_lo, // lower limit crossed
	output logic [15:0] hi_limit, // new upper limit
	output logic [15:0] lo_limit, // new lower limit
	output logic alert_n_o, // alert pin level when driven
	output logic alert_oe // alert pin drive enable
);
	generate
		if (STAGES < 1 || STAGES > (1 << STAGE_W)) begin : g_chk
			$error("atcal_core stage count does not fit stage width");
		end
	endgenerate

	// ---------------------------------------------------------------
	// arithmetic helpers
	// ---------------------------------------------------------------
	// saturate a signed intermediate into the 16-bit code range
	function automatic logic [15:0] sat16(input logic signed [19:0] v);
		if (v < 0) begin
			return 16'h0000;
		end else if (v > 20'sh0FFFF) begin
			return 16'hFFFF;
		end
		return v[15:0];
	endfunction

	// span/4 + ((span - span/4)/16) * code, giving 25% up to 95.3%
	function automatic logic [15:0] lim_val(input logic [15:0] base,
		input logic [15:0] span, input logic [3:0] code, input logic dn);
		logic [15:0] q;
		logic [15:0] rest;
		logic [19:0] off;
		q = span >> 2;
		rest = (span - q) >> 4;
		off = 20'(q) + 20'(rest) * 20'(code); // see R17
		if (dn) begin
			return sat16($signed(20'(base)) - $signed(off));
		end
		return sat16($signed(20'(base)) + $signed(off));
	endfunction

	// move a value toward a target by (target - value) >> sh
	function automatic logic [15:0] track(input logic [15:0] v,
		input logic [15:0] tgt, input logic [3:0] sh);
		logic signed [19:0] d;
		d = $signed(20'(tgt)) - $signed(20'(v));
		return sat16($signed(20'(v)) + (d >>> sh));
	endfunction

	// part of a span magnitude given by a window code in sixteenths
	function automatic logic [15:0] win_dist(input logic [15:0] mag,
		input logic [3:0] win);
		logic [19:0] p;
		p = 20'(mag) * 20'(win);
		return p[19:4];
	endfunction

	// ---------------------------------------------------------------
	// control registers
	// ---------------------------------------------------------------
	logic [14:0] ctrl_a_r;
	logic [15:0] ctrl_b_r;
	logic [15:0] ctrl_c_r;
	logic alert_r;
	logic alert_set;
	logic cal_en;
	logic slow_en;
	assign cal_en = ctrl_a_r[ATCAL_BIT_CAL_EN];
	assign slow_en = ctrl_a_r[ATCAL_BIT_SLOW_EN];

	// host writes; the alert bit of control a is status that the host clears by writing one
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctrl_a_r <= ATCAL_CTRL_A_RST[14:0];
			ctrl_b_r <= ATCAL_CTRL_B_RST;
			ctrl_c_r <= ATCAL_CTRL_C_RST;
		end else if (reg_wr) begin
			case (reg_addr) // see R15
				ATCAL_OFS_CTRL_A: begin
					ctrl_a_r <= reg_wdata[14:0];
				end
				ATCAL_OFS_CTRL_B: begin
					ctrl_b_r <= reg_wdata;
				end
				ATCAL_OFS_CTRL_C: begin
					ctrl_c_r <= reg_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// read data registered; unmapped addresses read zero
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			reg_rdata <= 16'h0000;
		end else begin
			case (reg_addr)
				ATCAL_OFS_CTRL_A: begin
					reg_rdata <= {alert_r, ctrl_a_r};
				end
				ATCAL_OFS_CTRL_B: begin
					reg_rdata <= ctrl_b_r;
				end
				ATCAL_OFS_CTRL_C: begin
					reg_rdata <= ctrl_c_r;
				end
				default: begin
					reg_rdata <= 16'h0000;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// stage memories and sequencing
	// ---------------------------------------------------------------
	atcal_fsm_e fsm_r;
	logic [STAGE_W-1:0] stage_r;
	logic [15:0] data_r;
	logic [STAGES-1:0] stage_ok_r;
	logic take;
	logic upd;
	logic [STAGE_W-1:0] mem_addr;
	atcal_setup_s su;
	atcal_state_s cur;
	atcal_state_s nxt;
	atcal_state_s st_wdata;
	logic st_we;

	assign setup_ready = (fsm_r == ST_IDLE);
	assign conv_ready = (fsm_r == ST_IDLE) && !setup_wr;
	assign take = conv_valid && conv_ready;
	assign upd = (fsm_r == ST_UPDATE) && stage_ok_r[stage_r];
	assign mem_addr = (fsm_r == ST_UPDATE) ? stage_r :
		(setup_wr ? setup_stage : conv_stage);
	assign st_we = upd || (setup_wr && setup_ready);
	// a setup write restarts the stage from its initial spans
	assign st_wdata = upd ? nxt : atcal_state_s'{seeded: 1'b0,
		base: 16'h0000,
		max_avg: 16'h0000, min_avg: 16'h0000,
		span_hi: setup_data.span_hi_init, span_lo: setup_data.span_lo_init,
		hi_lim: 16'hFFFF, lo_lim: 16'h0000};

	// per-stage setup and compensation state kept in RAM, see R14
	atcal_ram #(.W($bits(atcal_setup_s)), .DEPTH(STAGES), .AW(STAGE_W))
	u_setup_ram (
		.clk(ref_clk),
		.addr(mem_addr),
		.we(setup_wr && setup_ready),
		.wdata(setup_data),
		.rdata(su)
	);
	atcal_ram #(.W($bits(atcal_state_s)), .DEPTH(STAGES), .AW(STAGE_W))
	u_state_ram (
		.clk(ref_clk),
		.addr(mem_addr),
		.we(st_we),
		.wdata(st_wdata),
		.rdata(cur)
	);

	// one result in, one read cycle, one update cycle
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			fsm_r <= ST_IDLE;
			stage_r <= '0;
			data_r <= 16'h0000;
		end else begin
			case (fsm_r)
				ST_IDLE: begin
					if (take) begin
						fsm_r <= ST_UPDATE;
						stage_r <= conv_stage;
						data_r <= conv_data;
					end
				end
				ST_UPDATE: begin
					fsm_r <= ST_IDLE;
				end
				default: begin
					fsm_r <= ST_IDLE;
				end
			endcase
		end
	end

	// a stage is usable only after its setup has been written
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			stage_ok_r <= '0;
		end else if (setup_wr && setup_ready) begin
			stage_ok_r[setup_stage] <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// compensation arithmetic
	// ---------------------------------------------------------------
	logic hit_hi;
	logic hit_lo;
	logic touched;
	logic rise_ok;
	logic fall_ok;
	logic base_go;
	logic [15:0] diff;
	logic [15:0] tgt_hi;
	logic [15:0] tgt_lo;

	// rise against the upper limit, fall against the lower, see R16
	assign hit_hi = cur.seeded && (data_r > cur.hi_lim);
	assign hit_lo = cur.seeded && (data_r < cur.lo_lim);
	assign touched = hit_hi || hit_lo;
	// peak windows measured from the running averages, see R11 R12
	assign rise_ok = data_r >= cur.max_avg - win_dist((cur.max_avg >
		cur.base) ? cur.max_avg - cur.base : 16'h0000, su.rise_win);
	assign fall_ok = data_r <= cur.min_avg + win_dist((cur.base >
		cur.min_avg) ? cur.base - cur.min_avg : 16'h0000, su.fall_win);
	assign diff = (data_r > cur.base) ? data_r - cur.base :
		cur.base - data_r;
	// slow filter takes a sample only when it really moved, see R18
	assign base_go = slow_en && !prox_active && (diff > ctrl_b_r);

	always_comb begin
		nxt = cur;
		tgt_hi = 16'h0000;
		tgt_lo = 16'h0000;
		if (!cur.seeded) begin
			// first sample after setup seeds baseline and averages
			nxt.seeded = 1'b1;
			nxt.base = data_r;
			nxt.max_avg = data_r;
			nxt.min_avg = data_r;
		end else if (cal_en) begin
			if (rise_ok) begin
				nxt.max_avg = track(cur.max_avg, data_r,
					ctrl_c_r[ATCAL_AVG_SHIFT_LSB +: 4]); // see R11
			end
			if (fall_ok) begin
				nxt.min_avg = track(cur.min_avg, data_r,
					ctrl_c_r[ATCAL_AVG_SHIFT_LSB +: 4]); // see R12
			end
			if (!touched) begin // see R1
				if (base_go) begin
					nxt.base = track(cur.base, data_r,
						ctrl_c_r[ATCAL_SF_SHIFT_LSB +: 4]); // see R2
				end
				tgt_hi = (nxt.max_avg > nxt.base) ?
					nxt.max_avg - nxt.base : 16'h0000;
				tgt_lo = (nxt.base > nxt.min_avg) ?
					nxt.base - nxt.min_avg : 16'h0000;
				// spans follow drift of the peaks about the baseline
				nxt.span_hi = track(cur.span_hi, tgt_hi,
					ctrl_c_r[ATCAL_SPAN_STEP_LSB +: 4]); // see R7
				nxt.span_lo = track(cur.span_lo, tgt_lo,
					ctrl_c_r[ATCAL_SPAN_STEP_LSB +: 4]); // see R7
				// a touch cannot drag spans outside nominal, see R9 R20
				if (nxt.span_hi > su.clamp_hi) nxt.span_hi = su.clamp_hi;
				if (nxt.span_hi < su.clamp_lo) nxt.span_hi = su.clamp_lo;
				if (nxt.span_lo > su.clamp_hi) nxt.span_lo = su.clamp_hi;
				if (nxt.span_lo < su.clamp_lo) nxt.span_lo = su.clamp_lo;
			end
		end
		// limits always follow the latest baseline and spans, see R6
		nxt.hi_lim = lim_val(nxt.base, nxt.span_hi, su.rise_sens,
			1'b0); // see R4 R19
		nxt.lo_lim = lim_val(nxt.base, nxt.span_lo, su.fall_sens,
			1'b1); // see R3
	end

	// ---------------------------------------------------------------
	// results and alert
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			res_valid <= 1'b0;
			res_stage <= '0;
			touch_hi <= 1'b0;
			touch_lo <= 1'b0;
			hi_limit <= 16'h0000;
			lo_limit <= 16'h0000;
		end else begin
			res_valid <= upd;
			if (upd) begin
				res_stage <= stage_r;
				touch_hi <= hit_hi;
				touch_lo <= hit_lo;
				hi_limit <= nxt.hi_lim;
				lo_limit <= nxt.lo_lim;
			end
		end
	end

	// sticky alert; a new crossing beats a host clear in one cycle
	assign alert_set = upd && touched;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			alert_r <= 1'b0;
		end else if (alert_set) begin
			alert_r <= 1'b1; // see R13
		end else if (reg_wr && reg_addr == ATCAL_OFS_CTRL_A &&
			reg_wdata[ATCAL_BIT_ALERT]) begin
			alert_r <= 1'b0;
		end
	end
	// open drain: only ever pulls low
	assign alert_n_o = 1'b0;
	assign alert_oe = alert_r;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_alert;
		@(posedge ref_clk) disable iff (srst)
		alert_set |=> alert_oe && !alert_n_o;
	endproperty
	a_alert: assert property (p_alert) else $error("alert missed"); // see R13
	property p_hold_touched;
		@(posedge ref_clk) disable iff (srst)
		upd && touched |-> nxt.base == cur.base &&
			nxt.span_hi == cur.span_hi && nxt.span_lo == cur.span_lo;
	endproperty
	a_hold_touched: assert property (p_hold_touched) // see R1
		else $error("compensation ran while touched");
	property p_slow_gate;
		@(posedge ref_clk) disable iff (srst)
		upd && cur.seeded && (!slow_en || prox_active) |->
			nxt.base == cur.base;
	endproperty
	a_slow_gate: assert property (p_slow_gate) // see R18
		else $error("baseline moved while gated");
	property p_clamp;
		@(posedge ref_clk) disable iff (srst)
		upd && cur.seeded && cal_en && !touched &&
			su.clamp_lo <= su.clamp_hi |->
			nxt.span_hi <= su.clamp_hi && nxt.span_hi >= su.clamp_lo &&
			nxt.span_lo <= su.clamp_hi && nxt.span_lo >= su.clamp_lo;
	endproperty
	a_clamp: assert property (p_clamp) // see R20
		else $error("span outside clamps");
	property p_rise_win;
		@(posedge ref_clk) disable iff (srst)
		upd && cur.seeded && !rise_ok |-> nxt.max_avg == cur.max_avg;
	endproperty
	a_rise_win: assert property (p_rise_win) // see R11
		else $error("max average moved outside window");
	property p_fall_win;
		@(posedge ref_clk) disable iff (srst)
		upd && cur.seeded && !fall_ok |-> nxt.min_avg == cur.min_avg;
	endproperty
	a_fall_win: assert property (p_fall_win) // see R12
		else $error("min average moved outside window");
	property p_dir;
		@(posedge ref_clk) disable iff (srst)
		upd && cur.seeded && data_r > cur.hi_lim |=>
			res_valid && touch_hi && !touch_lo ##1 !res_valid;
	endproperty
	a_dir: assert property (p_dir) // see R16
		else $error("rise not flagged on upper limit");
	property p_relimit;
		@(posedge ref_clk) disable iff (srst)
		upd && (nxt.span_hi != cur.span_hi) |=>
			hi_limit >= $past(nxt.base) ||
			hi_limit == 16'hFFFF;
	endproperty
	a_relimit: assert property (p_relimit) // see R6
		else $error("upper limit not rebuilt");
endmodule

// >>> atcal_host_model.sv
// host-side model that hands stage setup records to the calibrator
`timescale 1ns/1ps
module atcal_host_model
	import atcal_pkg::*;
(
	input wire logic ref_clk, // clock
	input wire logic go, // start one setup write
	input wire logic [3:0] stage_in, // stage to set up
	input wire atcal_setup_s rec_in, // record to send
	input wire logic setup_ready, // device takes setup
	output logic setup_wr, // setup request
	output logic [3:0] setup_stage, // stage index
	output atcal_setup_s setup_data, // stage record
	output logic busy // write outstanding
);
	// ------------------------------------------------------------
	// setup request, held whole until taken
	// ------------------------------------------------------------
	initial begin
		setup_wr = 1'b0;
		setup_stage = 4'h0;
		setup_data = '0;
		busy = 1'b0;
	end
	// released lines show inverted values so stale data never looks valid
	always @(posedge ref_clk) begin
		if (setup_wr && setup_ready) begin
			setup_wr <= 1'b0;
			busy <= 1'b0;
			setup_stage <= ~setup_stage;
			setup_data <= ~setup_data;
		end else if (go && !busy) begin
			setup_wr <= 1'b1;
			busy <= 1'b1;
			setup_stage <= stage_in;
			setup_data <= rec_in;
		end
	end
endmodule

// >>> atcal_pkg.sv
// shared constants and record layouts of the ambient tracking calibrator
package atcal_pkg;
	// ---------------------------------------------------------------
	// register port map
	// ---------------------------------------------------------------
	localparam int ATCAL_ADDR_W = 10;
	localparam logic [9:0] ATCAL_OFS_CTRL_A = 10'h002;
	localparam logic [9:0] ATCAL_OFS_CTRL_B = 10'h003;
	localparam logic [9:0] ATCAL_OFS_CTRL_C = 10'h004;
	localparam logic [15:0] ATCAL_CTRL_A_RST = 16'h0000;
	localparam logic [15:0] ATCAL_CTRL_B_RST = 16'h0040;
	localparam logic [15:0] ATCAL_CTRL_C_RST = 16'h0242;
	// control a fields
	localparam int ATCAL_BIT_CAL_EN = 0;
	localparam int ATCAL_BIT_SLOW_EN = 1;
	localparam int ATCAL_BIT_ALERT = 15;
	// control c fields, each four bits wide
	localparam int ATCAL_SF_SHIFT_LSB = 0;
	localparam int ATCAL_SPAN_STEP_LSB = 4;
	localparam int ATCAL_AVG_SHIFT_LSB = 8;
	// ---------------------------------------------------------------
	// per-stage records
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [15:0] span_hi_init;
		logic [15:0] span_lo_init;
		logic [15:0] clamp_hi;
		logic [15:0] clamp_lo;
		logic [3:0] rise_sens;
		logic [3:0] fall_sens;
		logic [3:0] rise_win;
		logic [3:0] fall_win;
	} atcal_setup_s;
	typedef struct packed {
		logic seeded;
		logic [15:0] base;
		logic [15:0] max_avg;
		logic [15:0] min_avg;
		logic [15:0] span_hi;
		logic [15:0] span_lo;
		logic [15:0] hi_lim;
		logic [15:0] lo_lim;
	} atcal_state_s;
	typedef enum {ST_IDLE, ST_UPDATE} atcal_fsm_e;
endpackage

// >>> atcal_ram.sv
// single-port stage memory with registered read data
`timescale 1ns/1ps
module atcal_ram #(
	parameter int W = 16,
	parameter int DEPTH = 12,
	parameter int AW = 4
) (
	input wire logic clk, // clock
	input wire logic [AW-1:0] addr, // word address
	input wire logic we, // write strobe
	input wire logic [W-1:0] wdata, // write data
	output logic [W-1:0] rdata // read data, old word on write
);
	logic [W-1:0] mem [DEPTH];
	generate
		if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_chk
			$error("atcal_ram depth does not fit address");
		end
	endgenerate
	// ---------------------------------------------------------------
	// storage
	// ---------------------------------------------------------------
	// contents are not reset; callers track which words are valid
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule

// >>> tb.sv
// self-checking bench of the ambient tracking calibrator core
`timescale 1ns/1ps
module tb;
	import atcal_pkg::*;
	logic ref_clk, srst, reg_wr, conv_valid, prox_active, go;
	logic [9:0] reg_addr;
	logic [15:0] reg_wdata, conv_data, reg_rdata, hi_limit, lo_limit;
	logic [3:0] conv_stage, stage_in, res_stage, setup_stage;
	logic setup_wr, setup_ready, conv_ready, res_valid, touch_hi, touch_lo;
	logic alert_n_o, alert_oe, busy;
	atcal_setup_s rec_in, setup_data;
	atcal_setup_s recs [10];
	logic [15:0] bases [10];
	int mismatches, tests_run, cyc;
	logic [31:0] seed;
	wire alert_n;
	// open-drain pin with pull-up
	assign alert_n = alert_oe ? alert_n_o : 1'b1;
	// ------------------------------------------------------------
	// design and host model
	// ------------------------------------------------------------
	atcal_core #(.STAGES(12), .STAGE_W(4)) atcal_core_inst (
		.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.setup_wr(setup_wr), .setup_ready(setup_ready),
		.setup_stage(setup_stage), .setup_data(setup_data),
		.conv_valid(conv_valid), .conv_ready(conv_ready),
		.conv_stage(conv_stage), .conv_data(conv_data),
		.prox_active(prox_active), .res_valid(res_valid),
		.res_stage(res_stage), .touch_hi(touch_hi), .touch_lo(touch_lo),
		.hi_limit(hi_limit), .lo_limit(lo_limit),
		.alert_n_o(alert_n_o), .alert_oe(alert_oe));
	atcal_host_model atcal_host_model_inst (
		.ref_clk(ref_clk), .go(go), .stage_in(stage_in), .rec_in(rec_in),
		.setup_ready(setup_ready), .setup_wr(setup_wr),
		.setup_stage(setup_stage), .setup_data(setup_data), .busy(busy));
	// ------------------------------------------------------------
	// clock, watchdog, helpers
	// ------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// ceiling far above the roughly 160 cycles the sequence needs
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			test_done();
		end
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// limit offset: quarter span plus scaled remainder, no saturation here
	function automatic logic [15:0] lim(input logic [15:0] b, s,
		input logic [3:0] c, input logic dn);
		logic [19:0] d;
		d = {4'h0, s >> 2} + ({4'h0, (s - (s >> 2)) >> 4} * c);
		return dn ? b - d[15:0] : b + d[15:0];
	endfunction
	// one span step toward a target, step from control c, within clamps
	function automatic logic [15:0] trk(input logic [15:0] v, t,
		input atcal_setup_s r);
		logic signed [19:0] d;
		d = $signed({4'h0, t}) - $signed({4'h0, v});
		d = $signed({4'h0, v}) +
			(d >>> ATCAL_CTRL_C_RST[ATCAL_SPAN_STEP_LSB +: 4]);
		if (d > $signed({4'h0, r.clamp_hi})) begin
			return r.clamp_hi;
		end else if (d < $signed({4'h0, r.clamp_lo})) begin
			return r.clamp_lo;
		end
		return d[15:0];
	endfunction
	task automatic check(input string what, input logic [15:0] exp, got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic step();
		@(posedge ref_clk);
		#1;
	endtask
	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		step();
		reg_wr = 1'b0;
		reg_wdata = ~d;
		step();
	endtask
	task automatic rd(input logic [9:0] a, output logic [15:0] d);
		reg_addr = a;
		step();
		d = reg_rdata;
	endtask
	// offer one result, then count cycles from the take to res_valid
	task automatic conv(input logic [3:0] s, input logic [15:0] d,
		output int n);
		logic rdy;
		conv_stage = s;
		conv_data = d;
		conv_valid = 1'b1;
		n = 0;
		do begin
			rdy = conv_ready;
			step();
			n++;
		end while (rdy !== 1'b1 && n < 8);
		conv_valid = 1'b0;
		conv_data = ~d;
		n = 0;
		do begin
			step();
			n++;
		end while (res_valid !== 1'b1 && n < 4);
	endtask
	task automatic test_done();
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [15:0] v, hx, lx;
		int n, s;
		seed = 32'd57816;
		mismatches = 0;
		tests_run = 0;
		cyc = 0;
		srst = 1'b1;
		reg_wr = 1'b0;
		reg_addr = 10'h000;
		reg_wdata = 16'h0000;
		conv_valid = 1'b0;
		conv_stage = 4'h0;
		conv_data = 16'h0000;
		prox_active = 1'b0;
		go = 1'b0;
		stage_in = 4'h0;
		rec_in = '0;
		repeat (3) @(posedge ref_clk);
		#1;
		srst = 1'b0;
		// reset values, unmapped place, read/write of c, alert bit of a
		rd(ATCAL_OFS_CTRL_A, v); check("ctrl_a", ATCAL_CTRL_A_RST, v);
		rd(ATCAL_OFS_CTRL_B, v); check("ctrl_b", ATCAL_CTRL_B_RST, v);
		rd(ATCAL_OFS_CTRL_C, v); check("ctrl_c", ATCAL_CTRL_C_RST, v);
		wr(10'h005, 16'h5A5A);
		rd(10'h005, v); check("unmapped", 16'h0000, v);
		hx = 16'(rnd());
		wr(ATCAL_OFS_CTRL_C, hx);
		rd(ATCAL_OFS_CTRL_C, v); check("ctrl_c rw", hx, v);
		wr(ATCAL_OFS_CTRL_C, ATCAL_CTRL_C_RST);
		wr(ATCAL_OFS_CTRL_A, 16'h8003);
		rd(ATCAL_OFS_CTRL_A, v); check("ctrl_a ro", 16'h0003, v);
		// set up stages 0..9; codes i and 15-i cover all sixteen levels
		for (int i = 0; i < 10; i++) begin
			rec_in.clamp_hi = 16'h0800 + 16'(rnd() & 32'h7FF);
			rec_in.clamp_lo = 16'h0100;
			// both spans start at 80% of the upper clamp
			rec_in.span_hi_init = 16'(rec_in.clamp_hi * 4 / 5);
			rec_in.span_lo_init = rec_in.span_hi_init;
			rec_in.rise_sens = 4'(i);
			rec_in.fall_sens = 4'(15 - i);
			rec_in.rise_win = 4'(rnd());
			rec_in.fall_win = 4'(rnd());
			recs[i] = rec_in;
			stage_in = 4'(i);
			go = 1'b1;
			do step(); while (busy !== 1'b1);
			go = 1'b0;
			do step(); while (busy !== 1'b0);
		end
		// seeding conversion: baseline is the sample, limits from spans
		for (int i = 0; i < 10; i++) begin
			bases[i] = 16'h8000 + 16'(rnd() & 32'h3FF);
			conv(4'(i), bases[i], n);
			check("latency", 16'd1, 16'(n));
			check("res_stage", 16'(i), {12'h000, res_stage});
			hx = lim(bases[i], recs[i].span_hi_init, recs[i].rise_sens, 0);
			lx = lim(bases[i], recs[i].span_lo_init, recs[i].fall_sens, 1);
			check("hi_limit", hx, hi_limit);
			check("lo_limit", lx, lo_limit);
			check("seed touch", 16'h0000, {touch_hi, touch_lo});
		end
		// rise past upper limit, alert, clear, then fall past lower limit
		hx = lim(bases[0], recs[0].span_hi_init, recs[0].rise_sens, 0);
		lx = lim(bases[0], recs[0].span_lo_init, recs[0].fall_sens, 1);
		conv(4'h0, hx + 16'h0001, n);
		check("rise touch", 16'h0002, {touch_hi, touch_lo});
		check("alert pin", 16'h0000, {15'h0, alert_n});
		check("held hi", hx, hi_limit);
		rd(ATCAL_OFS_CTRL_A, v); check("alert bit", 16'h8003, v);
		wr(ATCAL_OFS_CTRL_A, 16'h8003);
		check("alert clr", 16'h0001, {15'h0, alert_n});
		conv(4'h0, lx - 16'h0001, n);
		check("fall touch", 16'h0001, {touch_hi, touch_lo});
		check("held lo", lx, lo_limit);
		wr(ATCAL_OFS_CTRL_A, 16'h8003);
		// stage never set up: consumed without a result
		conv(4'hA, 16'h8000, n);
		check("no result", 16'd4, 16'(n));
		// untouched sample at the baseline pulls both spans toward zero
		hx = trk(recs[9].span_hi_init, 16'h0000, recs[9]);
		conv(4'h9, bases[9], n);
		v = lim(bases[9], hx, recs[9].rise_sens, 1'b0);
		check("drift hi", v, hi_limit);
		v = lim(bases[9], hx, recs[9].fall_sens, 1'b1);
		check("drift lo", v, lo_limit);
		// proximity keeps the baseline although the sample passed B
		prox_active = 1'b1;
		lx = trk(hx, 16'h0000, recs[9]);
		hx = trk(hx, 16'h0100 >> ATCAL_CTRL_C_RST[ATCAL_AVG_SHIFT_LSB +: 4],
			recs[9]);
		conv(4'h9, bases[9] + 16'h0100, n);
		v = lim(bases[9], hx, recs[9].rise_sens, 1'b0);
		check("prox hi", v, hi_limit);
		v = lim(bases[9], lx, recs[9].fall_sens, 1'b1);
		check("prox lo", v, lo_limit);
		prox_active = 1'b0;
		// random drift near the baseline, proximity toggling
		for (int k = 0; k < 40; k++) begin
			s = int'(rnd() % 10);
			prox_active = 1'(rnd() & 32'h1);
			conv(4'(s), bases[s] + 16'(rnd() & 32'h3F), n);
			check("rnd latency", 16'd1, 16'(n));
			check("rnd touch", 16'h0000, {touch_hi, touch_lo});
			check("rnd order", 16'h0001, {15'h0, hi_limit > lo_limit});
		end
		prox_active = 1'b0;
		test_done();
	end
endmodule
